// [src/fsa_pkg.sv]
package fsa_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_SYNC_LO = 12'h124;
  localparam logic [11:0] OFS_SYNC_HI = 12'h128;
  localparam logic [11:0] OFS_ACK_TX  = 12'h140;
  localparam logic [11:0] OFS_ACK_RX  = 12'h144;
  localparam logic [11:0] OFS_CTRL    = 12'h160;
  localparam logic [11:0] OFS_DIV     = 12'h164;
  localparam logic [11:0] OFS_STAT    = 12'h168;
  localparam logic [11:0] OFS_WEND    = 12'h16c;

  ////////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int unsigned FIELD_W     = 12;
  localparam int unsigned LO_FIELD    = 0;
  localparam int unsigned HI_FIELD    = 16;
  localparam int unsigned CTRL_STD    = 0;
  localparam int unsigned CTRL_SLOT   = 1;
  localparam int unsigned CTRL_TWU    = 16;
  localparam int unsigned STD_HI_BITS = 8;
  localparam int unsigned STAT_ACK    = 0;
  localparam int unsigned STAT_WIN    = 1;
  localparam int unsigned STAT_RXOFF  = 2;
  localparam int unsigned STAT_SYNC   = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and lengths
  localparam logic [31:0] SYNC_RST      = 32'h0000_0000;
  localparam logic [11:0] DLY_RST       = 12'h000;
  localparam logic [6:0]  SYNC_LEN_FULL = 7'h40;
  localparam logic [6:0]  SYNC_LEN_STD  = 7'h28;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: one bit period of the 250 kb/s bit clock is one quarter symbol
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BIT_PERIOD_NS = 4000;
  localparam int unsigned BIT_CYCLES    = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] DIV_RST       = 16'(BIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [1:0] {
    AK_IDLE  = 2'b00,
    AK_DELAY = 2'b01,
    AK_SLOT  = 2'b10
  } fsa_ack_t;

  typedef enum logic {
    SY_IDLE = 1'b0,
    SY_SEND = 1'b1
  } fsa_sync_t;

endpackage

// [src/fsa_timer.sv]
`timescale 1ns/10ps
module fsa_timer #(
  parameter int unsigned W = 12
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         start,
  input  wire logic         tick,
  input  wire logic [W-1:0] value,
  // result
  output logic              done,
  output logic              busy
);

  if (W < 1 || W > 16) begin : g_chk
    $error("fsa_timer: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } fsa_tmr_st_t;

  fsa_tmr_st_t s, n;

  // zero delay finishes at once, otherwise counts down bit ticks
  always_comb begin
    n      = s;
    n.done = 1'b0;
    if (start) begin
      if (value == '0) begin
        n.done = 1'b1;
        n.busy = 1'b0;
      end else begin
        n.cnt  = value;
        n.busy = 1'b1;
      end
    end else if (s.busy && tick) begin
      if (s.cnt == W'(1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = s.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.done;
  assign busy = s.busy;

endmodule

// [src/fsa_core.sv]
// Summary of operation
// - low sync word held, sent first
// - high sync word sent right after low
// - standard mode uses only high word's low byte
// - ack delay tuned for 12-symbol ack start
// - slotted mode waits next backoff slot after delay
// - ack delay counts quarter symbols to warm-up
// - zero ack delay starts warm-up at once when not slotted
// - poll delay from poll ack to data
// - restart gap keeps receiver off N bits
// - search window opens N quarter symbols after tx
// - zero search delay starts receiver warm-up at once
// - search window closes N quarter symbols after tx
// - tx warm-up leads preamble by N bits
`timescale 1ns/10ps
module fsa_core #(
  parameter int unsigned DIV_W = 16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // sequencer events
  input  wire logic        rx_frame_done,
  input  wire logic        tx_done,
  input  wire logic        poll_ack_done,
  input  wire logic        rx_stop,
  input  wire logic        tx_req,
  input  wire logic        backoff_slot,
  input  wire logic        sync_load,
  // modem controls
  output logic             ack_warmup_start,
  output logic             polled_data_start,
  output logic             rx_warmup_start,
  output logic             ack_search_open,
  output logic             rx_off,
  output logic             rx_restart,
  output logic             tx_warmup_start,
  output logic             preamble_go,
  output logic             sync_bit,
  output logic             sync_valid,
  output logic             bit_tick
);

  if (DIV_W < 4 || DIV_W > 16) begin : g_chk
    $error("fsa_core: DIV_W out of range");
  end

  localparam int unsigned FW = fsa_pkg::FIELD_W;

  typedef struct packed {
    logic [31:0]         sync_lo;
    logic [31:0]         sync_hi;
    logic [FW-1:0]       ack_dly;
    logic [FW-1:0]       poll_dly;
    logic [FW-1:0]       srch;
    logic [FW-1:0]       gap;
    logic [FW-1:0]       wend;
    logic [FW-1:0]       twu;
    logic                std;
    logic                slot;
    logic [DIV_W-1:0]    div;
    logic [DIV_W-1:0]    divcnt;
    logic                tick;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    fsa_pkg::fsa_ack_t   ak;
    fsa_pkg::fsa_sync_t  sy;
    logic [63:0]         sh;
    logic [6:0]          left;
    logic                sync_bit;
    logic                sync_valid;
    logic                ack_go;
    logic                poll_go;
    logic                rxwu_go;
    logic                win;
    logic                rx_off;
    logic                rx_rst;
    logic                txwu_go;
    logic                pre_go;
  } fsa_core_st_t;

  fsa_core_st_t s, n;

  ////////////////////////////////////////////////////////////////////////////////
  // delay timers, all on the shared bit tick

  logic ack_done;
  logic poll_done;
  logic srch_done;
  logic wend_done;
  logic gap_done;
  logic twu_done;

  fsa_timer #(.W(FW)) u_ack (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rx_frame_done),
    .tick    (s.tick),
    .value   (s.ack_dly),
    .done    (ack_done),
    .busy    ()
  );

  fsa_timer #(.W(FW)) u_poll (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (poll_ack_done),
    .tick    (s.tick),
    .value   (s.poll_dly),
    .done    (poll_done),
    .busy    ()
  );

  fsa_timer #(.W(FW)) u_srch (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tx_done),
    .tick    (s.tick),
    .value   (s.srch),
    .done    (srch_done),
    .busy    ()
  );

  fsa_timer #(.W(FW)) u_wend (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tx_done),
    .tick    (s.tick),
    .value   (s.wend),
    .done    (wend_done),
    .busy    ()
  );

  fsa_timer #(.W(FW)) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rx_stop),
    .tick    (s.tick),
    .value   (s.gap),
    .done    (gap_done),
    .busy    ()
  );

  fsa_timer #(.W(FW)) u_twu (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tx_req),
    .tick    (s.tick),
    .value   (s.twu),
    .done    (twu_done),
    .busy    ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register read mux

  function automatic logic [31:0] rd_mux(input fsa_core_st_t r, input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      fsa_pkg::OFS_SYNC_LO: d = r.sync_lo;
      fsa_pkg::OFS_SYNC_HI: d = r.sync_hi;
      fsa_pkg::OFS_ACK_TX: begin
        d[fsa_pkg::LO_FIELD +: FW] = r.ack_dly;
        d[fsa_pkg::HI_FIELD +: FW] = r.poll_dly;
      end
      fsa_pkg::OFS_ACK_RX: begin
        d[fsa_pkg::LO_FIELD +: FW] = r.srch;
        d[fsa_pkg::HI_FIELD +: FW] = r.gap;
      end
      fsa_pkg::OFS_CTRL: begin
        d[fsa_pkg::CTRL_STD]       = r.std;
        d[fsa_pkg::CTRL_SLOT]      = r.slot;
        d[fsa_pkg::CTRL_TWU +: FW] = r.twu;
      end
      fsa_pkg::OFS_DIV: d[DIV_W-1:0] = r.div;
      fsa_pkg::OFS_STAT: begin
        d[fsa_pkg::STAT_ACK]   = (r.ak != fsa_pkg::AK_IDLE);
        d[fsa_pkg::STAT_WIN]   = r.win;
        d[fsa_pkg::STAT_RXOFF] = r.rx_off;
        d[fsa_pkg::STAT_SYNC]  = (r.sy == fsa_pkg::SY_SEND);
      end
      fsa_pkg::OFS_WEND: d[fsa_pkg::LO_FIELD +: FW] = r.wend;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a == fsa_pkg::OFS_SYNC_LO || a == fsa_pkg::OFS_SYNC_HI ||
           a == fsa_pkg::OFS_ACK_TX  || a == fsa_pkg::OFS_ACK_RX  ||
           a == fsa_pkg::OFS_CTRL    || a == fsa_pkg::OFS_DIV     ||
           a == fsa_pkg::OFS_STAT    || a == fsa_pkg::OFS_WEND;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n            = s;
    n.pready     = 1'b0;
    n.pslverr    = 1'b0;
    n.ack_go     = 1'b0;
    n.poll_go    = 1'b0;
    n.rxwu_go    = 1'b0;
    n.rx_rst     = 1'b0;
    n.txwu_go    = 1'b0;
    n.pre_go     = 1'b0;
    n.sync_valid = 1'b0;

    // bit clock divider, ratio div+1
    if (s.divcnt >= s.div) begin
      n.divcnt = '0;
      n.tick   = 1'b1;
    end else begin
      n.divcnt = s.divcnt + DIV_W'(1);
      n.tick   = 1'b0;
    end

    // apb: one wait state, write lands on the edge that drops pready
    if (psel && penable && !s.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !mapped(paddr);
      n.prdata  = pwrite ? 32'h0000_0000 : rd_mux(s, paddr);
    end
    if (psel && penable && s.pready && pwrite) begin
      case (paddr)
        fsa_pkg::OFS_SYNC_LO: n.sync_lo = pwdata;
        fsa_pkg::OFS_SYNC_HI: n.sync_hi = pwdata;
        fsa_pkg::OFS_ACK_TX: begin
          n.ack_dly  = pwdata[fsa_pkg::LO_FIELD +: FW];
          n.poll_dly = pwdata[fsa_pkg::HI_FIELD +: FW];
        end
        fsa_pkg::OFS_ACK_RX: begin
          n.srch = pwdata[fsa_pkg::LO_FIELD +: FW];
          n.gap  = pwdata[fsa_pkg::HI_FIELD +: FW];
        end
        fsa_pkg::OFS_CTRL: begin
          n.std  = pwdata[fsa_pkg::CTRL_STD];
          n.slot = pwdata[fsa_pkg::CTRL_SLOT];
          n.twu  = pwdata[fsa_pkg::CTRL_TWU +: FW];
        end
        fsa_pkg::OFS_DIV:  n.div  = pwdata[DIV_W-1:0];
        fsa_pkg::OFS_WEND: n.wend = pwdata[fsa_pkg::LO_FIELD +: FW];
        default: n.div = s.div;
      endcase
    end

    // ack warm-up sequencing
    case (s.ak)
      fsa_pkg::AK_IDLE: begin
        if (rx_frame_done) begin
          n.ak = fsa_pkg::AK_DELAY;
        end
      end
      fsa_pkg::AK_DELAY: begin
        if (ack_done) begin
          if (s.slot) begin
            n.ak = fsa_pkg::AK_SLOT;
          end else begin
            n.ack_go = 1'b1;
            n.ak     = fsa_pkg::AK_IDLE;
          end
        end
      end
      fsa_pkg::AK_SLOT: begin
        if (backoff_slot) begin
          n.ack_go = 1'b1;
          n.ak     = fsa_pkg::AK_IDLE;
        end
      end
      default: n.ak = fsa_pkg::AK_IDLE;
    endcase

    n.poll_go = poll_done;
    n.rxwu_go = srch_done;
    n.win     = (s.win | srch_done) & ~wend_done;

    // receiver off for the gap, then restart
    if (rx_stop) begin
      n.rx_off = 1'b1;
    end else if (gap_done && s.rx_off) begin
      n.rx_off = 1'b0;
      n.rx_rst = 1'b1;
    end

    n.txwu_go = tx_req;
    n.pre_go  = twu_done;

    // sync pattern: low word first, lsb first
    case (s.sy)
      fsa_pkg::SY_IDLE: begin
        if (sync_load) begin
          n.sh[31:0] = s.sync_lo;
          if (s.std) begin
            n.sh[63:32] = {24'h00_0000, s.sync_hi[fsa_pkg::STD_HI_BITS-1:0]};
            n.left      = fsa_pkg::SYNC_LEN_STD;
          end else begin
            n.sh[63:32] = s.sync_hi;
            n.left      = fsa_pkg::SYNC_LEN_FULL;
          end
          n.sy = fsa_pkg::SY_SEND;
        end
      end
      fsa_pkg::SY_SEND: begin
        if (s.tick) begin
          n.sync_bit   = s.sh[0];
          n.sync_valid = 1'b1;
          n.sh         = {1'b0, s.sh[63:1]};
          n.left       = s.left - 7'h01;
          if (s.left == 7'h01) begin
            n.sy = fsa_pkg::SY_IDLE;
          end
        end
      end
      default: n.sy = fsa_pkg::SY_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s     <= '0;
      s.div <= DIV_W'(fsa_pkg::DIV_RST);
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata            = s.prdata;
  assign pready            = s.pready;
  assign pslverr           = s.pslverr;
  assign ack_warmup_start  = s.ack_go;
  assign polled_data_start = s.poll_go;
  assign rx_warmup_start   = s.rxwu_go;
  assign ack_search_open   = s.win;
  assign rx_off            = s.rx_off;
  assign rx_restart        = s.rx_rst;
  assign tx_warmup_start   = s.txwu_go;
  assign preamble_go       = s.pre_go;
  assign sync_bit          = s.sync_bit;
  assign sync_valid        = s.sync_valid;
  assign bit_tick          = s.tick;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_seen;
    rx_stop ##1 rx_off;
  endsequence

  a_zero_ack_start: assert property (
    rx_frame_done && s.ak == fsa_pkg::AK_IDLE && s.ack_dly == '0 && !s.slot
    |-> ##2 ack_warmup_start)
    else $error("ack warm-up not immediate");
  a_slot_aligned: assert property (
    ack_warmup_start && s.slot |-> $past(backoff_slot))
    else $error("slotted ack off slot boundary");
  a_zero_search: assert property (
    tx_done && s.srch == '0 |-> ##2 rx_warmup_start)
    else $error("rx warm-up not immediate");
  a_zero_poll: assert property (
    poll_ack_done && s.poll_dly == '0 |-> ##2 polled_data_start)
    else $error("polled data not immediate");
  a_rx_gap_off: assert property (
    s_stop_seen |-> !rx_restart)
    else $error("receiver not held off");
  a_rx_restart: assert property (
    rx_restart |-> !rx_off && $past(rx_off))
    else $error("restart without off period");
  a_warmup_lead: assert property (
    tx_req && s.twu == '0 |-> ##1 tx_warmup_start ##1 preamble_go)
    else $error("preamble lead wrong");
  a_std_high_byte: assert property (
    sync_load && s.sy == fsa_pkg::SY_IDLE && s.std |=> s.sh[63:40] == 24'h00_0000)
    else $error("std mode high bits used");
  a_bit_tick: assert property (
    bit_tick && s.div != '0 |=> !bit_tick)
    else $error("bit tick too fast");
  a_apb_pulse: assert property (
    pready |=> !pready)
    else $error("pready held");

endmodule

// [verif/fsa_modem_model.sv]
`timescale 1ns/10ps
module fsa_modem_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // sync stream from the framer
  input  wire logic        sync_load,
  input  wire logic        sync_bit,
  input  wire logic        sync_valid,
  // collected pattern
  output logic      [63:0] got,
  output logic      [6:0]  cnt
);
  ////////////////////////////////////////////////////////////////////////////////
  // bits land in arrival order, first bit at position 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got <= '0;
      cnt <= '0;
    end else if (sync_load) begin
      cnt <= '0;
    end else if (sync_valid && cnt < 7'h40) begin
      got[cnt[5:0]] <= sync_bit;
      cnt           <= cnt + 7'h01;
    end
  end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} fsa_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [6:0]  ev = '0;
  wire  [4:0]  outs;
  logic        txwu;
  logic        tick;
  logic        sync_bit;
  logic        sync_valid;
  logic        rx_off;
  logic        win;
  logic [63:0] got;
  logic [6:0]  cnt;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [11:0] dreg [5] = '{fsa_pkg::OFS_ACK_TX, fsa_pkg::OFS_ACK_TX, fsa_pkg::OFS_ACK_RX,
                            fsa_pkg::OFS_ACK_RX, fsa_pkg::OFS_CTRL};
  int          shf [5] = '{0, 16, 0, 16, 16};
  fsa_row_t    rows [6] = '{
    '{1'b1, fsa_pkg::OFS_SYNC_LO, 32'ha5a5_5a5a, 32'ha5a5_5a5a, 1'b0},
    '{1'b1, fsa_pkg::OFS_SYNC_HI, 32'h1234_5678, 32'h1234_5678, 1'b0},
    '{1'b1, fsa_pkg::OFS_ACK_TX, 32'hffff_ffff, 32'h0fff_0fff, 1'b0},
    '{1'b1, fsa_pkg::OFS_ACK_RX, 32'hffff_ffff, 32'h0fff_0fff, 1'b0},
    '{1'b1, fsa_pkg::OFS_STAT, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{1'b1, 12'h200, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
  int          dk [8] = '{0, 0, 1, 2, 2, 3, 4, 4};
  int          dn [8] = '{0, 5, 7, 4, 0, 6, 3, 0};

  always #50 pclk = ~pclk;

  fsa_core u_fsa_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame_done(ev[0]), .poll_ack_done(ev[1]), .tx_done(ev[2]),
    .rx_stop(ev[3]), .tx_req(ev[4]), .backoff_slot(ev[5]), .sync_load(ev[6]),
    .ack_warmup_start(outs[0]), .polled_data_start(outs[1]), .rx_warmup_start(outs[2]),
    .ack_search_open(win), .rx_off(rx_off), .rx_restart(outs[3]), .tx_warmup_start(txwu),
    .preamble_go(outs[4]), .sync_bit(sync_bit), .sync_valid(sync_valid), .bit_tick(tick));
  fsa_modem_model u_fsa_modem_model (.pclk(pclk), .presetn(presetn), .sync_load(ev[6]),
    .sync_bit(sync_bit), .sync_valid(sync_valid), .got(got), .cnt(cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task chk_rng(input string nm, input int lo, input int hi, input int s);
    n_tests++;
    if (s < lo || s > hi) begin
      error_cnt++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    if (i >= 20) begin
      chk("pready", 1, 0);
      end_sim();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task fire(input int k);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
  endtask

  task wait_out(input int k, output int lat);
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
      if (k == 3 && lat == 2) chk("rx_off", 1, rx_off);
      if (k == 4 && lat == 1) chk("tx warm-up", 1, txwu);
    end while (outs[k] !== 1'b1 && lat < 5000);
    if (lat >= 5000) begin
      chk("wait timeout", 1, 0);
      end_sim();
    end
  endtask

  task measure(input int k, input int n);
    int lat;
    apb(1'b1, dreg[k], 32'(n) << shf[k]);
    fire(k);
    wait_out(k, lat);
    if (n == 0) chk_rng($sformatf("zero delay %0d", k), 2, 2, lat);
    else chk_rng($sformatf("delay %0d", k), n + 1, n + (k == 4 ? 4 : 3), lat);
    if (k == 2 && n != 0) begin
      @(posedge pclk);
      chk("search open", 1, win);
      lat++;
      // window end register holds 10 quarter symbols
      do begin
        @(posedge pclk);
        lat++;
      end while (win !== 1'b0 && lat < 100);
      chk_rng("search close", 11, 13, lat);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int lat;
    logic seen;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, fsa_pkg::OFS_SYNC_HI, '0);
    chk("sync_hi reset", fsa_pkg::SYNC_RST, rd);
    apb(1'b0, fsa_pkg::OFS_DIV, '0);
    chk("div reset", 32'(fsa_pkg::DIV_RST), rd);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, '0);
      chk($sformatf("reg %h", rows[i].a), rows[i].e, rd);
      chk($sformatf("err %h", rows[i].a), rows[i].er, er);
    end
    $display("test registers done");
    apb(1'b1, fsa_pkg::OFS_DIV, '0);
    apb(1'b1, fsa_pkg::OFS_WEND, 32'h0000_000a);
    // poll delay kept above the zero warm-up time
    foreach (dk[i]) measure(dk[i], dn[i]);
    $display("test delays done");
    apb(1'b1, fsa_pkg::OFS_CTRL, 32'h0000_0002);
    apb(1'b1, fsa_pkg::OFS_ACK_TX, 32'h0000_0003);
    fire(0);
    seen = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      seen = seen | outs[0];
    end
    chk("slot wait", 0, seen);
    fire(5);
    wait_out(0, lat);
    chk_rng("slot start", 1, 2, lat);
    $display("test slotted done");
    for (int std = 0; std < 2; std++) begin
      apb(1'b1, fsa_pkg::OFS_CTRL, 32'(std));
      fire(6);
      lat = 0;
      while (cnt !== (std ? fsa_pkg::SYNC_LEN_STD : fsa_pkg::SYNC_LEN_FULL) && lat < 400) begin
        @(posedge pclk);
        lat++;
      end
      if (lat >= 400) begin
        chk("sync timeout", 1, 0);
        end_sim();
      end
      if (std) chk("sync std", 64'h78a5a55a5a, got[39:0]);
      else chk("sync full", 64'h12345678a5a55a5a, got);
      repeat (10) @(posedge pclk);
      chk("sync count", std ? 40 : 64, cnt);
    end
    $display("test sync done");
    // reset in mid-run while the receiver is held off
    fire(3);
    @(posedge pclk);
    chk("rx_off before reset", 1, rx_off);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("rx_off in reset", 0, rx_off);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, fsa_pkg::OFS_ACK_TX, '0);
    chk("ack_tx reset", 32'h0000_0000, rd);
    apb(1'b0, fsa_pkg::OFS_DIV, '0);
    chk("div reset", 32'(fsa_pkg::DIV_RST), rd);
    lat = 0;
    while (tick !== 1'b1 && lat < 100) begin
      @(posedge pclk);
      lat++;
    end
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
    end while (tick !== 1'b1 && lat < 100);
    chk_rng("tick period", fsa_pkg::BIT_CYCLES, fsa_pkg::BIT_CYCLES, lat);
    $display("test mid reset done");
    end_sim();
  end
endmodule
